/* File: src/cts_pkg.sv */
// Package of constants and types for the cycle timing sequencer
package cts_pkg;

  // ****************************************************************
  // Machine cycle structure
  // ****************************************************************
  localparam int          STATES_PER_MC  = 4;
  localparam int          MAX_MC         = 9;
  localparam logic [3:0]  MC_ONE         = 4'h1;
  localparam logic [3:0]  MC_TWO         = 4'h2;
  localparam logic [3:0]  MC_THREE       = 4'h3;
  localparam logic [3:0]  MC_FOUR        = 4'h4;
  localparam logic [3:0]  MC_FIVE        = 4'h5;

  // ****************************************************************
  // Clock control stretch field
  // ****************************************************************
  localparam int          STRETCH_LSB    = 0;
  localparam int          STRETCH_W      = 3;
  localparam logic [2:0]  STRETCH_RST    = 3'h1;

  // ****************************************************************
  // Opcodes with special timing
  // ****************************************************************
  localparam logic [7:0]  OP_XMOV_RD_DP  = 8'he0;
  localparam logic [7:0]  OP_XMOV_RD_R0  = 8'he2;
  localparam logic [7:0]  OP_XMOV_RD_R1  = 8'he3;
  localparam logic [7:0]  OP_XMOV_WR_DP  = 8'hf0;
  localparam logic [7:0]  OP_XMOV_WR_R0  = 8'hf2;
  localparam logic [7:0]  OP_XMOV_WR_R1  = 8'hf3;
  localparam logic [7:0]  OP_COMPARE_JUMP_NOT_EQUAL_LO     = 8'hb4;
  localparam logic [7:0]  OP_COMPARE_JUMP_NOT_EQUAL_HI     = 8'hbf;
  localparam logic [7:0]  OP_DECREMENT_JUMP_NONZERO_REG_LO = 8'hd8;
  localparam logic [7:0]  OP_DECREMENT_JUMP_NONZERO_REG_HI = 8'hdf;
  localparam logic [7:0]  OP_DECREMENT_JUMP_NONZERO_DIR    = 8'hd5;
  localparam logic [7:0]  OP_JBC         = 8'h10;
  localparam logic [7:0]  OP_LCALL       = 8'h12;
  localparam logic [7:0]  OP_LJMP        = 8'h02;
  localparam logic [7:0]  OP_JB          = 8'h20;
  localparam logic [7:0]  OP_JNB         = 8'h30;
  localparam logic [7:0]  OP_SJMP        = 8'h80;
  localparam logic [7:0]  OP_JZ          = 8'h60;
  localparam logic [7:0]  OP_JNZ         = 8'h70;
  localparam logic [7:0]  OP_JC          = 8'h40;
  localparam logic [7:0]  OP_JNC         = 8'h50;
  localparam logic [7:0]  OP_RET         = 8'h22;
  localparam logic [7:0]  OP_RETI        = 8'h32;
  localparam logic [7:0]  OP_JMP_IND     = 8'h73;
  localparam logic [7:0]  OP_MUL         = 8'ha4;
  localparam logic [7:0]  OP_DIV         = 8'h84;
  localparam logic [4:0]  OP_AJMP_LOW    = 5'h01;
  localparam logic [4:0]  OP_ACALL_LOW   = 5'h11;

  // ****************************************************************
  // Clock states within a machine cycle, Gray order
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_1 = 2'b00,
    ST_2 = 2'b01,
    ST_3 = 2'b11,
    ST_4 = 2'b10
  } cts_state_t;

endpackage : cts_pkg

/* File: src/cts_dec_if.sv */
// Interface between sequencer and opcode length decoder
`timescale 1ns/10ps
interface cts_dec_if;
  logic [7:0] opcode;
  logic [2:0] stretch;
  logic [3:0] mc_len;
  logic       is_xmov;
  logic       xmov_wr;

  modport seq (output opcode, output stretch, input mc_len, input is_xmov, input xmov_wr);
  modport dec (input opcode, input stretch, output mc_len, output is_xmov, output xmov_wr);
endinterface : cts_dec_if

/* File: src/cts_len_dec.sv */
// Opcode to machine cycle count decoder
`timescale 1ns/10ps
module cts_len_dec (
  cts_dec_if.dec dec
);
  import cts_pkg::*;

  // ****************************************************************
  // Length decode
  // ****************************************************************
  logic [7:0] op;

  always_comb begin
    op          = dec.opcode;
    dec.is_xmov = 1'b0;
    dec.xmov_wr = 1'b0;
    dec.mc_len  = MC_ONE;
    if (op == OP_XMOV_RD_DP || op == OP_XMOV_RD_R0 || op == OP_XMOV_RD_R1 ||
        op == OP_XMOV_WR_DP || op == OP_XMOV_WR_R0 || op == OP_XMOV_WR_R1) begin
      dec.is_xmov = 1'b1;
      dec.xmov_wr = op[4];
      dec.mc_len  = MC_TWO + {1'b0, dec.stretch};
    end else if (op >= OP_COMPARE_JUMP_NOT_EQUAL_LO && op <= OP_COMPARE_JUMP_NOT_EQUAL_HI) begin
      dec.mc_len = MC_FOUR;
    end else if (op >= OP_DECREMENT_JUMP_NONZERO_REG_LO && op <= OP_DECREMENT_JUMP_NONZERO_REG_HI) begin
      dec.mc_len = MC_THREE;
    end else if (op == OP_DECREMENT_JUMP_NONZERO_DIR || op == OP_JBC) begin
      dec.mc_len = MC_FOUR;
    end else if (op == OP_LCALL || op == OP_LJMP || op == OP_JB || op == OP_JNB) begin
      dec.mc_len = MC_FOUR;
    end else if (op[4:0] == OP_AJMP_LOW || op[4:0] == OP_ACALL_LOW || op == OP_SJMP ||
                 op == OP_JZ || op == OP_JNZ || op == OP_JC || op == OP_JNC) begin
      dec.mc_len = MC_THREE;
    end else if (op == OP_MUL || op == OP_DIV) begin
      dec.mc_len = MC_FIVE;
    end else if (op == OP_RET || op == OP_RETI || op == OP_JMP_IND) begin
      dec.mc_len = MC_TWO;
    end else if (op[7:4] != 4'h0 && (op[3:0] == 4'h5 || op[3:0] == 4'h2 ||
                 op[3:0] == 4'h3 || op[3:0] == 4'h4)) begin
      dec.mc_len = MC_TWO;
    end
  end

endmodule // cts_len_dec

/* File: src/cts_seq.sv */
// Machine cycle and clock state sequencer with data move stretch
`timescale 1ns/10ps
// Operation
// - Four clock states per machine cycle, fixed order
// - Both clock edges used for timing
// - At most one opcode fetch per cycle
// - More than half of opcodes complete in one cycle
// - Two-cycle group, mostly two bytes
// - Cycle count from decoder, not bytes
// - Data move takes two to nine cycles
// - Read/write strobe lengthens with stretch
// - Remaining opcodes take three to five cycles
// - Exactly one of five length categories
// - Compare-jump opcodes take four cycles
// - Stretch from control bits two to zero
// - Stretch affects only data move
module cts_seq (
  input  wire logic                      CLK_SYS_IN,
  input  wire logic                      NRST_IN,
  input  wire logic                      RUN_IN,
  input  wire logic [7:0]                OPCODE_IN,
  input  wire logic [7:0]                CLOCK_CONTROL_REG_IN,
  output logic [1:0]                     STATE_OUT,
  output logic                           FETCH_OUT,
  output logic                           INSTR_DONE_OUT,
  output logic [3:0]                     MC_LEN_OUT,
  output logic [3:0]                     MC_COUNT_OUT,
  output logic                           CLK_HALF_OUT,
  output logic                           RD_N_OUT,
  output logic                           WR_N_OUT
);
  import cts_pkg::*;

  // ****************************************************************
  // Decoder hookup
  // ****************************************************************
  cts_dec_if dif ();
  cts_len_dec u_dec (.dec(dif));

  logic [7:0] opcode_r, opcode_nxt;
  logic [2:0] stretch_r, stretch_nxt;
  logic [3:0] len_r, len_nxt;
  logic [3:0] mc_r, mc_nxt;
  cts_state_t st_r, st_nxt;
  logic       busy_r, busy_nxt;
  logic       fetch_r, fetch_nxt;
  logic       done_r, done_nxt;
  logic       rd_n_r, rd_n_nxt;
  logic       wr_n_r, wr_n_nxt;
  logic       xmov_r, xmov_nxt;
  logic       xwr_r, xwr_nxt;
  logic       fall_r;
  logic       rise_r;

  assign dif.opcode  = OPCODE_IN;
  assign dif.stretch = stretch_r;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    opcode_nxt  = opcode_r;
    stretch_nxt = CLOCK_CONTROL_REG_IN[STRETCH_LSB +: STRETCH_W];
    len_nxt     = len_r;
    mc_nxt      = mc_r;
    busy_nxt    = busy_r;
    fetch_nxt   = 1'b0;
    done_nxt    = 1'b0;
    xmov_nxt    = xmov_r;
    xwr_nxt     = xwr_r;
    rd_n_nxt    = rd_n_r;
    wr_n_nxt    = wr_n_r;
    unique case (st_r)
      ST_1: st_nxt = ST_2;
      ST_2: st_nxt = ST_3;
      ST_3: st_nxt = ST_4;
      ST_4: st_nxt = ST_1;
    endcase
    if (st_r == ST_4) begin
      if (!busy_r || mc_r == len_r) begin
        done_nxt = busy_r;
        rd_n_nxt = 1'b1;
        wr_n_nxt = 1'b1;
        xmov_nxt = 1'b0;
        if (RUN_IN) begin
          fetch_nxt  = 1'b1;
          opcode_nxt = OPCODE_IN;
          len_nxt    = dif.mc_len;
          xmov_nxt   = dif.is_xmov;
          xwr_nxt    = dif.xmov_wr;
          mc_nxt     = MC_ONE;
          busy_nxt   = 1'b1;
        end else begin
          busy_nxt = 1'b0;
        end
      end else begin
        mc_nxt = mc_r + MC_ONE;
        if (xmov_r && mc_r == MC_ONE) begin
          rd_n_nxt = xwr_r;
          wr_n_nxt = !xwr_r;
        end
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      opcode_r  <= 8'h00;
      stretch_r <= STRETCH_RST;
      len_r     <= MC_ONE;
      mc_r      <= MC_ONE;
      st_r      <= ST_1;
      busy_r    <= 1'b0;
      fetch_r   <= 1'b0;
      done_r    <= 1'b0;
      rd_n_r    <= 1'b1;
      wr_n_r    <= 1'b1;
      xmov_r    <= 1'b0;
      xwr_r     <= 1'b0;
      rise_r    <= 1'b0;
    end else begin
      opcode_r  <= opcode_nxt;
      stretch_r <= stretch_nxt;
      len_r     <= len_nxt;
      mc_r      <= mc_nxt;
      st_r      <= st_nxt;
      busy_r    <= busy_nxt;
      fetch_r   <= fetch_nxt;
      done_r    <= done_nxt;
      rd_n_r    <= rd_n_nxt;
      wr_n_r    <= wr_n_nxt;
      xmov_r    <= xmov_nxt;
      xwr_r     <= xwr_nxt;
      rise_r    <= ~rise_r;
    end
  end

  // Falling edge phase marker
  always_ff @(negedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      fall_r <= 1'b0;
    end else begin
      fall_r <= rise_r;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign STATE_OUT      = st_r;
  assign FETCH_OUT      = fetch_r;
  assign INSTR_DONE_OUT = done_r;
  assign MC_LEN_OUT     = len_r;
  assign MC_COUNT_OUT   = mc_r;
  assign CLK_HALF_OUT   = fall_r;
  assign RD_N_OUT       = rd_n_r;
  assign WR_N_OUT       = wr_n_r;

endmodule // cts_seq

/* File: testbench/cts_seq_chk.sv */
// Assertion checker for the cycle timing sequencer
`timescale 1ns/10ps
module cts_seq_chk (
  input  wire logic       CLK_SYS_IN,
  input  wire logic       NRST_IN,
  input  wire logic [7:0] OPCODE_IN,
  input  wire logic [7:0] CLOCK_CONTROL_REG_IN,
  input  wire logic [1:0] STATE_OUT,
  input  wire logic       FETCH_OUT,
  input  wire logic       INSTR_DONE_OUT,
  input  wire logic [3:0] MC_LEN_OUT,
  input  wire logic [3:0] MC_COUNT_OUT,
  input  wire logic       CLK_HALF_OUT,
  input  wire logic       RD_N_OUT,
  input  wire logic       WR_N_OUT
);
  logic [5:0] cnt_r, cnt_nxt, lo_r, lo_nxt;
  logic [3:0] len_r, len_nxt;
  wire  logic [2:0] st = CLOCK_CONTROL_REG_IN[2:0];
  always_comb begin
    cnt_nxt = FETCH_OUT ? 6'h01 : cnt_r + 6'h01;
    len_nxt = FETCH_OUT ? MC_LEN_OUT : len_r;
    lo_nxt  = (!RD_N_OUT || !WR_N_OUT) ? lo_r + 6'h01 : 6'h00;
  end
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cnt_r <= 6'h00;
      len_r <= 4'h1;
      lo_r  <= 6'h00;
    end else begin
      cnt_r <= cnt_nxt;
      len_r <= len_nxt;
      lo_r  <= lo_nxt;
    end
  end
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!NRST_IN);
  a_state_walk: assert property (NRST_IN && STATE_OUT == 2'b00 |=> STATE_OUT == 2'b01 ##1
    STATE_OUT == 2'b11 ##1 STATE_OUT == 2'b10 ##1 STATE_OUT == 2'b00) else $error("bad state");
  a_half_toggle: assert property (NRST_IN && $past(NRST_IN) |->
    CLK_HALF_OUT != $past(CLK_HALF_OUT)) else $error("falling edge toggle missing");
  a_fetch_first: assert property (FETCH_OUT |-> STATE_OUT == 2'b00 &&
    MC_COUNT_OUT == 4'h1) else $error("fetch outside first state");
  a_fetch_gap: assert property (FETCH_OUT |=> !FETCH_OUT [*3]) else $error("fetch too close");
  a_done_time: assert property (INSTR_DONE_OUT |-> cnt_r == {len_r, 2'b00})
    else $error("instruction time wrong");
  a_strobe_width: assert property ($rose(RD_N_OUT) || $rose(WR_N_OUT) |->
    lo_r == {len_r, 2'b00} - 6'h04) else $error("strobe width wrong");
  a_cmp_jump_len: assert property (FETCH_OUT && $past(OPCODE_IN) inside {[8'hb4:8'hbf]} |->
    MC_LEN_OUT == 4'h4) else $error("compare jump length wrong");
  a_xmov_len: assert property (FETCH_OUT && $past(OPCODE_IN) == 8'he0 |->
    MC_LEN_OUT == {1'b0, $past(st, 2)} + 4'h2) else $error("data move length wrong");
endmodule // cts_seq_chk

/* File: testbench/cts_xmem_model.sv */
// External data memory model that times the access strobes
`timescale 1ns/10ps
module cts_xmem_model (
  input  wire logic       clk_in,
  input  wire logic       clr_in,
  input  wire logic       rd_n_in,
  input  wire logic       wr_n_in,
  output logic      [5:0] rd_w_out,
  output logic      [5:0] wr_w_out
);
  logic [5:0] rc, wc;
  always @(posedge clk_in) begin
    rc <= rd_n_in ? 6'h00 : rc + 6'h01;
    wc <= wr_n_in ? 6'h00 : wc + 6'h01;
    if (clr_in) begin
      rd_w_out <= 6'h00;
      wr_w_out <= 6'h00;
    end else begin
      if (rd_n_in && rc != 6'h00) rd_w_out <= rc;
      if (wr_n_in && wc != 6'h00) wr_w_out <= wc;
    end
  end
endmodule // cts_xmem_model

/* File: testbench/cts_seq_tb.sv */
// Testbench for the cycle timing sequencer
`timescale 1ns/10ps
module cts_seq_tb;
  import cts_pkg::*;
  logic       clk, nrst, run, clr, fetch, done, half, rd_n, wr_n;
  logic [7:0] opc, ccr;
  logic [1:0] st;
  logic [3:0] len, cnt;
  logic [5:0] rd_w, wr_w;
  int         err_total = 0, compares = 0, cyc = 0;
  cts_seq i_dut (.CLK_SYS_IN(clk), .NRST_IN(nrst), .RUN_IN(run), .OPCODE_IN(opc),
    .CLOCK_CONTROL_REG_IN(ccr), .STATE_OUT(st), .FETCH_OUT(fetch), .INSTR_DONE_OUT(done),
    .MC_LEN_OUT(len), .MC_COUNT_OUT(cnt), .CLK_HALF_OUT(half), .RD_N_OUT(rd_n), .WR_N_OUT(wr_n));
  cts_xmem_model i_mem (.clk_in(clk), .clr_in(clr), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .rd_w_out(rd_w), .wr_w_out(wr_w));
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run_op(logic [7:0] op, output logic [3:0] l, output int n);
    int i;
    clr <= 1'b1;
    opc <= op;
    run <= 1'b1;
    i = 0;
    do begin @(posedge clk); i++; end while (fetch !== 1'b1 && i < 20);
    clr <= 1'b0;
    run <= 1'b0;
    l = len;
    n = 0;
    do begin @(posedge clk); n++; end while (done !== 1'b1 && n < 60);
    @(posedge clk);
  endtask
  task automatic t_lengths();
    logic [7:0] ops [13] = '{8'h10, 8'hb4, 8'hb6, 8'hbf, 8'hd8, 8'hdf, 8'hd5, 8'h00, 8'h22, 8'h12,
                             8'hc5, 8'h80, 8'ha4};
    logic [3:0] exl [13] = '{4, 4, 4, 4, 3, 3, 4, 1, 2, 4, 2, 3, 5};
    logic [3:0] l;
    int         n;
    foreach (ops[k]) begin
      run_op(ops[k], l, n);
      chk("length", {4'h0, exl[k]}, {4'h0, l});
      chk("cycles", {2'h0, exl[k], 2'h0}, n[7:0]);
      chk("strobe", 8'h00, {2'h0, rd_w | wr_w});
    end
    $display("test lengths done");
  endtask
  task automatic t_stretch();
    logic [3:0] l;
    int         n;
    for (int s = 0; s < 8; s++) begin
      ccr <= {5'h00, s[2:0]};
      repeat (2) @(posedge clk);
      run_op(8'he0, l, n);
      chk("read length", 8'(s + 2), {4'h0, l});
      chk("read strobe", 8'(4 * (s + 1)), {2'h0, rd_w});
      run_op(8'hf3, l, n);
      chk("write strobe", 8'(4 * (s + 1)), {2'h0, wr_w});
      chk("write cycles", 8'(4 * (s + 2)), n[7:0]);
    end
    run_op(8'hbf, l, n);
    chk("other cycles", 8'h10, n[7:0]);
    ccr <= 8'h01;
    $display("test stretch done");
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    nrst = 1'b0;
    run  = 1'b0;
    clr  = 1'b0;
    opc  = 8'h00;
    ccr  = 8'h01;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_lengths();
    t_stretch();
    give_verdict();
  end
endmodule // cts_seq_tb
bind cts_seq cts_seq_chk u_chk (.*);
